/* File: inc/dbgpc_pkg.sv */
// Constants and types for the debug return-PC and exception priority unit
package dbgpc_pkg;
  // Address and instruction widths
  localparam int unsigned       DBGPC_AW          = 32;
  localparam int unsigned       DBGPC_IW          = 32;
  // One instruction address in bytes
  localparam logic [31:0]       DBGPC_ADDR_BYTES  = 32'h0000_0004;
  // Entry advance in addresses per entry cause
  localparam logic [31:0]       DBGPC_ENTRY_BKPT  = 32'h0000_0004;
  localparam logic [31:0]       DBGPC_ENTRY_EXC   = 32'h0000_0003;
  // Per-instruction advance in addresses
  localparam logic [31:0]       DBGPC_STEP_DBG    = 32'h0000_0001;
  localparam logic [31:0]       DBGPC_STEP_SYS    = 32'h0000_0003;
  // Minimum debug instructions before the final branch
  localparam logic [7:0]        DBGPC_MIN_INSNS   = 8'h02;
  // Scanned word layout: flag above 32-bit instruction
  localparam int unsigned       DBGPC_FLAG_POS    = 32;
  // Processor mode encodings
  localparam logic [4:0]        DBGPC_MODE_FIQ    = 5'h11;
  localparam logic [4:0]        DBGPC_MODE_IRQ    = 5'h12;
  localparam logic [4:0]        DBGPC_MODE_ABT    = 5'h17;
  // Status word field positions
  localparam int unsigned       DBGPC_IRQ_DIS_BIT = 7;
  localparam int unsigned       DBGPC_FIQ_DIS_BIT = 6;
  localparam int unsigned       DBGPC_MODE_LSB    = 0;
  // Status word after reset: supervisor mode, both interrupt kinds masked
  localparam logic [31:0]       DBGPC_STATUS_RST  = 32'h0000_00d3;
  // Entry cause
  typedef enum logic [2:0] {
    DBGPC_CAUSE_NONE, DBGPC_CAUSE_BKPT, DBGPC_CAUSE_WATCH,
    DBGPC_CAUSE_WATCH_EXC, DBGPC_CAUSE_HALT
  } dbgpc_cause_e;
  // Core state
  typedef enum logic [1:0] {
    DBGPC_RUN, DBGPC_EXC_FIRST, DBGPC_DEBUG, DBGPC_SYS
  } dbgpc_state_e;
endpackage : dbgpc_pkg

/* File: src/dbgpc_unit.sv */
// Debug-entry PC advance and exception priority logic of the core
//
// Operation
// RULE_01 - Breakpoint entry advances PC sixteen bytes
// RULE_02 - Debug-speed instruction advances PC four bytes
// RULE_03 - Debugger branches back 4+N+3S normally
// RULE_04 - Halt or watch-exception branches back 3+N+3S
// RULE_05 - Watchpoint resumes at following instruction
// RULE_06 - Aborted watchpoint: abort mode, vector, then debug
// RULE_07 - Exception during watchpoint: enter in its mode
// RULE_08 - Watchpoint with exception advances three addresses
// RULE_09 - Halt request advances three, no refetch
// RULE_10 - System-speed access advances three addresses
// RULE_11 - Aborted system access enters abort mode
// RULE_12 - Prefetch abort beats breakpoint
// RULE_13 - Debug entry disables interrupts
// RULE_14 - Interrupts affect only watchpoints, never breakpoints; here a halt with a pending interrupt also enters interrupt mode
// RULE_15 - Pending interrupt sets debug entry mode
// RULE_16 - Debug beats interrupt, interrupt remembered
// RULE_17 - Watchpoint beats data abort, abort remembered
// RULE_18 - Debugger runs two instructions before branch
// RULE_19 - Flag bit shifted first, then instruction
// RULE_20 - Re-executed aborting access triggers watchpoint again
// RULE_21 - Flag high runs next instruction system speed
// RULE_22 - Deferred exception latched, taken after exit
`timescale 1ns/100ps
module dbgpc_unit
  import dbgpc_pkg::*;
#(
  parameter logic [31:0] ABORT_VECTOR = 32'h0000_0010, // Data abort vector
  parameter logic [31:0] IRQ_VECTOR   = 32'h0000_0018  // Interrupt vector
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // Pipeline events, one-cycle pulses; halt and interrupt pins are levels
  input  wire logic                insn_retire,      // Normal instruction completes
  input  wire logic [DBGPC_AW-1:0] retire_pc,        // Address of that instruction
  input  wire logic                bkpt_hit,         // Breakpointed fetch executes
  input  wire logic [DBGPC_AW-1:0] bkpt_pc,          // Breakpointed address
  input  wire logic                prefetch_abort,   // Fetch abort on same fetch
  input  wire logic                watch_hit,        // Watchpointed access completes
  input  wire logic                data_abort,       // Data abort on an access
  input  wire logic                halt_request_input, // Debug halt request, pin
  input  wire logic                irq_pending,      // Interrupt request level, pin
  // Debug instruction feed
  input  wire logic                dbg_insn_valid,   // Scanned word executes
  input  wire logic [DBGPC_IW:0]   dbg_insn_word,    // Flag above instruction
  input  wire logic                dbg_is_branch,    // This word is the final branch
  input  wire logic                sys_done,         // System-speed access finished
  input  wire logic                sys_abort,        // System-speed access aborted
  input  wire logic                restart,          // Debugger resumes the core
  // Status words
  input  wire logic [31:0]         status_in,        // Status word before entry
  output logic [31:0]              current_status_word, // Live status word
  output logic [31:0]              saved_status_word,   // Status saved on exception
  // Program counter and state
  output logic [DBGPC_AW-1:0]      pc_ff,            // Core program counter
  output logic                     in_debug,         // Core halted in debug
  output logic                     exc_taken,        // Exception vector taken, pulse
  output logic                     pend_irq_ff,      // Remembered interrupt
  output logic                     pend_abort_ff,    // Remembered abort
  output logic [7:0]               dbg_count_ff,     // Debug instructions executed
  output dbgpc_cause_e             cause_ff          // Why debug was entered
);

  // Pin synchronisers
  logic halt_s1_ff, halt_s2_ff;   // Halt request sync chain
  logic irq_s1_ff, irq_s2_ff;     // Interrupt sync chain

  // Machine state
  dbgpc_state_e state_ff;         // Run, exception step, debug, system speed
  logic         sys_next_ff;      // Next debug word runs at system speed
  logic         exc_first_abt_ff; // Exception step is an abort, else interrupt

  // Decoded conditions
  logic bkpt_ok;                  // Breakpoint that survives prefetch abort
  logic watch_exc;                // Watchpoint hit with a simultaneous exception
  logic halt_now;                 // Synchronised halt while running
  logic flag_set;                 // Flag bit of the scanned word

  // RULE_13 mode helper, also masks interrupts
  function automatic logic [31:0] set_mode(input logic [31:0] sw, input logic [4:0] md);
    logic [31:0] r;
    r = sw;
    r[DBGPC_MODE_LSB +: 5] = md;
    r[DBGPC_IRQ_DIS_BIT]   = 1'b1;
    r[DBGPC_FIQ_DIS_BIT]   = 1'b1;
    return r;
  endfunction : set_mode

  // Two flops before logic reads asynchronous pins
  always_ff @(posedge clk) begin
    if (rst) begin
      halt_s1_ff <= 1'b0;
      halt_s2_ff <= 1'b0;
      irq_s1_ff  <= 1'b0;
      irq_s2_ff  <= 1'b0;
    end else begin
      halt_s1_ff <= halt_request_input;
      halt_s2_ff <= halt_s1_ff;
      irq_s1_ff  <= irq_pending;
      irq_s2_ff  <= irq_s1_ff;
    end
  end

  // RULE_12 prefetch abort wins
  assign bkpt_ok   = bkpt_hit && !prefetch_abort;
  // RULE_14 interrupts count only on watchpoints
  assign watch_exc = watch_hit && (data_abort || irq_s2_ff);
  assign halt_now  = halt_s2_ff && !bkpt_ok && !watch_hit;
  // RULE_21 flag position in the scanned word
  assign flag_set  = dbg_insn_word[DBGPC_FLAG_POS];
  assign in_debug  = (state_ff == DBGPC_DEBUG);

  // State sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff         <= DBGPC_RUN;
      exc_first_abt_ff <= 1'b0;
    end else begin
      case (state_ff)
        DBGPC_RUN: begin
          // RULE_06 exception step precedes debug
          if (state_ff == DBGPC_RUN && watch_exc) begin
            state_ff         <= DBGPC_EXC_FIRST;
            exc_first_abt_ff <= data_abort;
          end else if (bkpt_ok || watch_hit || halt_now) begin
            state_ff <= DBGPC_DEBUG;
          end
        end
        DBGPC_EXC_FIRST: begin
          state_ff <= DBGPC_DEBUG;
        end
        DBGPC_DEBUG: begin
          // RULE_21 word after a flagged one runs at system speed
          if (dbg_insn_valid && sys_next_ff && !dbg_is_branch) begin
            state_ff <= DBGPC_SYS;
          end else if (restart) begin
            state_ff <= DBGPC_RUN;
          end
        end
        DBGPC_SYS: begin
          if (sys_done || sys_abort) begin
            state_ff <= DBGPC_DEBUG;
          end
        end
        default: state_ff <= DBGPC_RUN;
      endcase
    end
  end

  // Entry cause record
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_ff <= DBGPC_CAUSE_NONE;
    end else if (state_ff == DBGPC_RUN) begin
      if (watch_exc) begin
        cause_ff <= DBGPC_CAUSE_WATCH_EXC;
      end else if (bkpt_ok) begin
        cause_ff <= DBGPC_CAUSE_BKPT;
      end else if (watch_hit) begin
        cause_ff <= DBGPC_CAUSE_WATCH;
      end else if (halt_now) begin
        cause_ff <= DBGPC_CAUSE_HALT;
      end
    end
  end

  // System-speed flag for the next debug word
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_next_ff <= 1'b0;
    end else if (state_ff != DBGPC_DEBUG && state_ff != DBGPC_SYS) begin
      sys_next_ff <= 1'b0;
    end else if (dbg_insn_valid && state_ff == DBGPC_DEBUG) begin
      // RULE_19 flag leads the instruction word
      sys_next_ff <= flag_set;
    end
  end

  // Debug instruction counter, saturating
  always_ff @(posedge clk) begin
    if (rst || state_ff == DBGPC_RUN) begin
      dbg_count_ff <= 8'h00;
    end else if (dbg_insn_valid && state_ff == DBGPC_DEBUG && dbg_count_ff != 8'hff) begin
      dbg_count_ff <= dbg_count_ff + 8'h01;
    end
  end

  // Program counter advance
  always_ff @(posedge clk) begin
    if (rst) begin
      pc_ff <= '0;
    end else begin
      case (state_ff)
        DBGPC_RUN: begin
          if (watch_exc) begin
            // RULE_06 fetch from vector first
            pc_ff <= data_abort ? ABORT_VECTOR : IRQ_VECTOR;
          end else if (bkpt_ok) begin
            // RULE_01 four addresses past breakpoint
            pc_ff <= bkpt_pc + DBGPC_ENTRY_BKPT * DBGPC_ADDR_BYTES;
          end else if (watch_hit) begin
            // RULE_05 base is the instruction after the access
            pc_ff <= retire_pc + DBGPC_ADDR_BYTES + DBGPC_ENTRY_BKPT * DBGPC_ADDR_BYTES;
          end else if (halt_now) begin
            // RULE_09 three past the next instruction, no refetch
            pc_ff <= retire_pc + DBGPC_ADDR_BYTES + DBGPC_ENTRY_EXC * DBGPC_ADDR_BYTES;
          end else if (insn_retire) begin
            pc_ff <= retire_pc + DBGPC_ADDR_BYTES;
          end
        end
        DBGPC_EXC_FIRST: begin
          // RULE_08 three addresses past the vector
          pc_ff <= pc_ff + DBGPC_ENTRY_EXC * DBGPC_ADDR_BYTES;
        end
        DBGPC_DEBUG: begin
          // RULE_02 one address per debug word
          if (dbg_insn_valid && !(sys_next_ff && !dbg_is_branch)) begin
            pc_ff <= pc_ff + DBGPC_STEP_DBG * DBGPC_ADDR_BYTES;
          end
        end
        DBGPC_SYS: begin
          // RULE_10 system access costs three
          if (sys_done || sys_abort) begin
            pc_ff <= pc_ff + DBGPC_STEP_SYS * DBGPC_ADDR_BYTES;
          end
        end
        default: pc_ff <= pc_ff;
      endcase
    end
  end

  // Status words and mode changes
  always_ff @(posedge clk) begin
    if (rst) begin
      current_status_word <= DBGPC_STATUS_RST;
      saved_status_word   <= 32'h0000_0000;
    end else if (state_ff == DBGPC_RUN) begin
      if (watch_exc) begin
        // RULE_07 take exception mode before debug
        saved_status_word   <= status_in;
        current_status_word <= set_mode(status_in, data_abort ? DBGPC_MODE_ABT : DBGPC_MODE_IRQ);
      end else if (bkpt_ok || watch_hit || halt_now) begin
        // RULE_15 pending interrupt sets mode, watch or halt only
        if (irq_s2_ff && !bkpt_ok) begin
          saved_status_word   <= status_in;
          current_status_word <= set_mode(status_in, DBGPC_MODE_IRQ);
        end else begin
          current_status_word <= set_mode(status_in, status_in[DBGPC_MODE_LSB +: 5]);
        end
      end
    end else if (state_ff == DBGPC_SYS && sys_abort) begin
      // RULE_11 abort mode before debug again
      saved_status_word   <= current_status_word;
      current_status_word <= set_mode(current_status_word, DBGPC_MODE_ABT);
    end else if (state_ff == DBGPC_EXC_FIRST) begin
      // RULE_13 interrupts masked on entry
      current_status_word[DBGPC_IRQ_DIS_BIT] <= 1'b1;
      current_status_word[DBGPC_FIQ_DIS_BIT] <= 1'b1;
    end
  end

  // Exception vector pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      exc_taken <= 1'b0;
    end else begin
      exc_taken <= (state_ff == DBGPC_RUN && watch_exc) || (state_ff == DBGPC_SYS && sys_abort);
    end
  end

  // Deferred interrupt record, set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_irq_ff <= 1'b0;
    end else if (irq_s2_ff && (state_ff != DBGPC_RUN || bkpt_ok || watch_hit || halt_now)) begin
      // RULE_16 debug first, interrupt remembered
      pend_irq_ff <= 1'b1;
    end else if (state_ff == DBGPC_RUN && !irq_s2_ff) begin
      // RULE_22 acted on once running again
      pend_irq_ff <= 1'b0;
    end
  end

  // Deferred abort record
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_abort_ff <= 1'b0;
    end else if (state_ff == DBGPC_RUN && watch_hit && data_abort) begin
      // RULE_17 watchpoint first, abort remembered
      pend_abort_ff <= 1'b1;
    end else if (state_ff == DBGPC_RUN && insn_retire) begin
      // RULE_22 cleared when handler code retires; RULE_20 re-run re-arms it
      pend_abort_ff <= 1'b0;
    end
  end

  // Assertions
  property p_bkpt_pc;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_RUN && bkpt_ok && !watch_exc) |=> (pc_ff == $past(bkpt_pc) + 32'h10 && in_debug);
  endproperty
  a_bkpt_pc: assert property (p_bkpt_pc) else $error("breakpoint entry pc wrong"); // RULE_01

  property p_dbg_step;
    @(posedge clk) disable iff (rst)
      (in_debug && dbg_insn_valid && !sys_next_ff) |=> (pc_ff == $past(pc_ff) + 32'h4);
  endproperty
  a_dbg_step: assert property (p_dbg_step) else $error("debug step not four bytes"); // RULE_02

  property p_halt_pc;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_RUN && halt_now) |=> (pc_ff == $past(retire_pc) + 32'h10);
  endproperty
  a_halt_pc: assert property (p_halt_pc) else $error("halt entry pc wrong"); // RULE_09

  property p_wexc;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_RUN && watch_exc && data_abort) |=>
        (pc_ff == ABORT_VECTOR && !in_debug) ##1 (in_debug && pc_ff == ABORT_VECTOR + 32'hc);
  endproperty
  a_wexc: assert property (p_wexc) else $error("watch abort sequence wrong"); // RULE_08

  property p_sys_step;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_SYS && sys_done) |=> (pc_ff == $past(pc_ff) + 32'hc && in_debug);
  endproperty
  a_sys_step: assert property (p_sys_step) else $error("system step not three"); // RULE_10

  property p_sys_abt;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_SYS && sys_abort) |=> (current_status_word[4:0] == DBGPC_MODE_ABT && exc_taken);
  endproperty
  a_sys_abt: assert property (p_sys_abt) else $error("system abort mode missing"); // RULE_11

  property p_pabt;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_RUN && bkpt_hit && prefetch_abort && !watch_hit && !halt_s2_ff) |=> !in_debug;
  endproperty
  a_pabt: assert property (p_pabt) else $error("breakpoint beat prefetch abort"); // RULE_12

  property p_irq_mask;
    @(posedge clk) disable iff (rst)
      in_debug |-> current_status_word[DBGPC_IRQ_DIS_BIT];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupts left enabled"); // RULE_13

  property p_bkpt_noirq;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_RUN && bkpt_ok && !watch_hit) |=> current_status_word[4:0] == $past(status_in[4:0]);
  endproperty
  a_bkpt_noirq: assert property (p_bkpt_noirq) else $error("breakpoint changed mode"); // RULE_14

  property p_abt_mem;
    @(posedge clk) disable iff (rst)
      (state_ff == DBGPC_RUN && watch_hit && data_abort) |=> pend_abort_ff;
  endproperty
  a_abt_mem: assert property (p_abt_mem) else $error("abort not remembered"); // RULE_17

  c_bkpt: cover property (@(posedge clk) state_ff == DBGPC_RUN && bkpt_ok);
  c_wexc: cover property (@(posedge clk) state_ff == DBGPC_EXC_FIRST);
  c_sys:  cover property (@(posedge clk) state_ff == DBGPC_SYS && sys_done);
  c_halt: cover property (@(posedge clk) state_ff == DBGPC_RUN && halt_now);

endmodule : dbgpc_unit

/* File: verif/dbgpc_debugger.sv */
// External debugger model feeding scanned words into the core
`timescale 1ns/100ps
module dbgpc_debugger
  import dbgpc_pkg::*;
(
  // Clock
  input  wire logic          clk,
  // Word feed towards the core
  output logic               dbg_insn_valid,
  output logic [DBGPC_IW:0]  dbg_insn_word,
  output logic               dbg_is_branch,
  // System-speed completion and resume
  output logic               sys_done,
  output logic               sys_abort,
  output logic               restart
);
  localparam logic [31:0] NOP_INSN  = 32'he1a00000; // Register move to itself
  localparam logic [31:0] LOAD_INSN = 32'he5900000; // Plain word load

  // Idle levels at time zero
  initial begin
    dbg_insn_valid = 1'b0;
    dbg_insn_word  = '0;
    dbg_is_branch  = 1'b0;
    sys_done       = 1'b0;
    sys_abort      = 1'b0;
    restart        = 1'b0;
  end

  // One word for one cycle; bus scrambled after so stale data never looks valid
  task automatic send(input logic flag, input logic [31:0] insn, input logic br, input int gap);
    @(negedge clk);
    dbg_insn_valid = 1'b1;
    dbg_insn_word  = {flag, insn};
    dbg_is_branch  = br;
    @(negedge clk);
    dbg_insn_valid = 1'b0;
    dbg_is_branch  = 1'b0;
    dbg_insn_word  = ~dbg_insn_word;
    repeat (gap) @(negedge clk);
  endtask : send

  // Whole debug session; k is the backward branch in addresses
  task automatic session(input logic [31:0] entry, input int n, input logic [7:0] smask,
                         input logic abort_sys, input int gap, output logic [31:0] k);
    int   i;
    int   nn;
    int   nd;
    int   ns;
    logic sys_next;
    nn       = (n < 2) ? 2 : n;
    nd       = 0;
    ns       = 0;
    sys_next = 1'b0;
    for (i = 0; i < nn; i++) begin
      if (sys_next) begin
        // word after a flagged one runs at system speed
        send(1'b0, LOAD_INSN, 1'b0, 0);
        repeat (gap + 1) @(negedge clk);
        sys_abort = abort_sys;
        sys_done  = !abort_sys;
        @(negedge clk);
        sys_abort = 1'b0;
        sys_done  = 1'b0;
        ns++;
        sys_next  = 1'b0;
      end else begin
        send(smask[i], NOP_INSN, 1'b0, gap);
        nd++;
        sys_next = smask[i];
      end
    end
    k = entry + 32'(nd + 1) + 32'(3 * ns);
    send(1'b0, {8'hea, 24'(-k)}, 1'b1, gap);
  endtask : session

  // Resume pulse
  task automatic resume();
    @(negedge clk);
    restart = 1'b1;
    @(negedge clk);
    restart = 1'b0;
  endtask : resume
endmodule : dbgpc_debugger

/* File: verif/dbgpc_unit_test.sv */
// Self-checking bench for debug entry PC advance and priorities
`timescale 1ns/100ps
module dbgpc_unit_test;
  import dbgpc_pkg::*;
  localparam logic [31:0] ABT_VEC = 32'h00000010; // Abort vector under test
  localparam logic [31:0] IRQ_VEC = 32'h00000018; // Interrupt vector under test
  localparam logic [31:0] A       = 32'h00001000; // Breakpoint address
  localparam logic [31:0] W       = 32'h00002000; // Watched access address
  // One entry case with its expected outcome
  typedef struct {
    logic bk; logic irq; logic ab; logic [31:0] addr; logic [31:0] pc; logic [31:0] entry;
    dbgpc_cause_e cause; logic [4:0] mode; logic exc; int n; logic [7:0] smask; logic [31:0] ret;
  } dbgpc_row_s;
  logic               clk = 1'b0, rst = 1'b1;               // Clock and reset
  logic               insn_retire = 1'b0, bkpt_hit = 1'b0;  // Pipeline pulses
  logic               prefetch_abort = 1'b0, watch_hit = 1'b0, data_abort = 1'b0;
  logic               halt_request_input = 1'b0, irq_pending = 1'b0; // Pins
  logic [31:0]        retire_pc = '0, bkpt_pc = '0;         // Event addresses
  logic [31:0]        status_in = 32'h00000010;             // Status at entry
  logic               dbg_insn_valid, dbg_is_branch, sys_done, sys_abort, restart;
  logic [DBGPC_IW:0]  dbg_insn_word;                        // Scanned word
  logic [31:0]        current_status_word, saved_status_word, pc_ff;
  logic               in_debug, exc_taken, pend_irq_ff, pend_abort_ff;
  logic [7:0]         dbg_count_ff;                         // Words executed
  dbgpc_cause_e       cause_ff;                             // Entry cause
  int                 err_total = 0, checks = 0;            // Verdict counters
  dbgpc_row_s         rows [5];                             // Ordinary cases
  dbgpc_row_s         row;                                  // Current case
  logic [31:0]        k;                                    // Branch length
  logic               hit, exc;                             // Entry observations
  int                 r;                                    // Row index

  // 125 MHz clock
  always #4 clk = ~clk;

  dbgpc_unit #(.ABORT_VECTOR(ABT_VEC), .IRQ_VECTOR(IRQ_VEC)) dbgpc_unit_inst (
    .clk(clk), .rst(rst), .insn_retire(insn_retire), .retire_pc(retire_pc), .bkpt_hit(bkpt_hit),
    .bkpt_pc(bkpt_pc), .prefetch_abort(prefetch_abort), .watch_hit(watch_hit), .data_abort(data_abort),
    .halt_request_input(halt_request_input), .irq_pending(irq_pending), .dbg_insn_valid(dbg_insn_valid),
    .dbg_insn_word(dbg_insn_word), .dbg_is_branch(dbg_is_branch), .sys_done(sys_done),
    .sys_abort(sys_abort), .restart(restart), .status_in(status_in),
    .current_status_word(current_status_word), .saved_status_word(saved_status_word), .pc_ff(pc_ff),
    .in_debug(in_debug), .exc_taken(exc_taken), .pend_irq_ff(pend_irq_ff),
    .pend_abort_ff(pend_abort_ff), .dbg_count_ff(dbg_count_ff), .cause_ff(cause_ff));

  dbgpc_debugger dbgpc_debugger_inst (
    .clk(clk), .dbg_insn_valid(dbg_insn_valid), .dbg_insn_word(dbg_insn_word),
    .dbg_is_branch(dbg_is_branch), .sys_done(sys_done), .sys_abort(sys_abort), .restart(restart));

  // Verdict and end of run, single exit point
  task automatic finish_test();
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Drop event pulses after one edge, then wait bounded for debug state
  task automatic wait_dbg(output logic h, output logic e);
    int i;
    h = 1'b0;
    e = 1'b0;
    for (i = 0; i < 8 && !h; i++) begin
      @(negedge clk);
      {bkpt_hit, watch_hit, data_abort, prefetch_abort, insn_retire} = '0;
      if (exc_taken === 1'b1) e = 1'b1;
      if (in_debug === 1'b1) h = 1'b1;
    end
  endtask : wait_dbg

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end

  initial begin
    rows[0] = '{1'b1, 1'b0, 1'b0, A, A + 32'h10, 32'h4, DBGPC_CAUSE_BKPT, 5'h10, 1'b0, 2, 8'h01, A};
    rows[1] = '{1'b0, 1'b0, 1'b0, W, W + 32'h14, 32'h4, DBGPC_CAUSE_WATCH, 5'h10, 1'b0, 3, 8'h02, W + 32'h4};
    rows[2] = '{1'b0, 1'b0, 1'b1, W, ABT_VEC + 32'hc, 32'h3, DBGPC_CAUSE_WATCH_EXC, DBGPC_MODE_ABT,
                1'b1, 2, 8'h00, ABT_VEC};
    rows[3] = '{1'b0, 1'b1, 1'b0, W, IRQ_VEC + 32'hc, 32'h3, DBGPC_CAUSE_WATCH_EXC, DBGPC_MODE_IRQ,
                1'b1, 4, 8'h05, IRQ_VEC};
    rows[4] = '{1'b1, 1'b1, 1'b0, A, A + 32'h10, 32'h4, DBGPC_CAUSE_BKPT, 5'h10, 1'b0, 2, 8'h00, A};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    // Ordinary entry cases, one loop
    for (r = 0; r < 5; r++) begin
      row = rows[r];
      irq_pending = row.irq;
      // Retire once so an abort record from the previous row is acted on
      insn_retire = 1'b1;
      @(negedge clk);
      insn_retire = 1'b0;
      repeat (2) @(negedge clk);
      retire_pc  = row.addr;
      bkpt_pc    = row.addr;
      bkpt_hit   = row.bk;
      watch_hit  = !row.bk;
      data_abort = row.ab;
      wait_dbg(hit, exc);
      chk(32'(hit), 32'h1, "no debug entry");
      chk(32'(exc), 32'(row.exc), "vector taken");
      chk(pc_ff, row.pc, "entry pc");
      chk(32'(cause_ff), 32'(row.cause), "cause");
      chk(32'(current_status_word[4:0]), 32'(row.mode), "entry mode");
      chk(32'(current_status_word[7:6]), 32'h3, "irq not disabled");
      chk(32'(pend_irq_ff), 32'(row.irq), "irq record");
      chk(32'(pend_abort_ff), 32'(row.ab), "abort record");
      if (row.exc) chk(saved_status_word, status_in, "saved status");
      dbgpc_debugger_inst.session(row.entry, row.n, row.smask, 1'b0, r, k);
      chk(pc_ff - (k << 2), row.ret, "return target");
      chk(32'(dbg_count_ff), 32'(row.n + 1), "word count");
      irq_pending = 1'b0;
      dbgpc_debugger_inst.resume();
      repeat (3) @(negedge clk);
      chk(32'(in_debug), 32'h0, "still in debug");
      chk(32'(pend_irq_ff), 32'h0, "irq record not acted on");
    end
    // Prefetch abort voids the breakpoint
    bkpt_pc        = A;
    bkpt_hit       = 1'b1;
    prefetch_abort = 1'b1;
    wait_dbg(hit, exc);
    chk(32'(hit), 32'h0, "breakpoint beat prefetch abort");
    // Halt request after a retired instruction
    retire_pc          = W;
    insn_retire        = 1'b1;
    halt_request_input = 1'b1;
    wait_dbg(hit, exc);
    chk(pc_ff, W + 32'h10, "halt entry pc");
    chk(32'(cause_ff), 32'(DBGPC_CAUSE_HALT), "halt cause");
    halt_request_input = 1'b0;
    // Aborted system-speed access inside the session
    dbgpc_debugger_inst.session(32'h3, 2, 8'h01, 1'b1, 1, k);
    chk(32'(current_status_word[4:0]), 32'(DBGPC_MODE_ABT), "sys abort mode");
    chk(32'(in_debug), 32'h1, "sys abort left debug");
    dbgpc_debugger_inst.resume();
    // Reset in mid-run
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(pc_ff, 32'h0, "reset pc");
    chk(current_status_word, 32'h000000d3, "reset status");
    chk(saved_status_word, 32'h0, "reset saved");
    chk({exc_taken, dbg_count_ff, in_debug, pend_irq_ff, pend_abort_ff, cause_ff}, 32'h0, "reset flags");
    finish_test();
  end
endmodule : dbgpc_unit_test
